// File: core/hdps_regs.svh
// Link codes, message limits and check constants of the polled slave link.
`ifndef HDPS_REGS_SVH
`define HDPS_REGS_SVH
`define HDPS_SOH      8'h01
`define HDPS_STX      8'h02
`define HDPS_ETX      8'h03
`define HDPS_EOT      8'h04
`define HDPS_ENQ      8'h05
`define HDPS_ACK      8'h06
`define HDPS_DLE      8'h10
`define HDPS_NAK      8'h15
`define HDPS_BCAST    8'hFF
`define HDPS_MIN_LEN  8'h06
`define HDPS_MAX_LEN  250
`define HDPS_CRC_POLY 16'hA001
`define HDPS_HDR_B0   1
`define HDPS_HDR_B1   2
`define HDPS_HDR_B2   4
`define HDPS_HDR_B3   5
`endif

// File: core/hdps_pkg.sv
// Types shared by the polled slave link transceiver.
package hdps_pkg;
  typedef struct packed {
    logic [7:0] max_sends;
    logic [7:0] station;
    logic       bcast_en;
    logic       crc_sel;
    logic       addr_chk;
  } hdps_cfg_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       perr;
  } hdps_rx_s;
  typedef enum logic [4:0] {
    S_IDLE, S_ADDR, S_STX, S_BUILD, S_CHK, S_CHK2, S_JUDGE, S_DELIV,
    S_PADDR, S_PBCC, S_POLL, S_REQ, S_FETCH, S_TX, S_CTL, S_FREQ, S_FDRAIN
  } hdps_st_e;
  typedef enum logic [2:0] {
    P_DLE1, P_CODE, P_DATA, P_DLE2, P_ETX, P_CK0, P_CK1
  } hdps_ph_e;
endpackage

// File: core/hdps_link.sv
// Slave transceiver of a polled half-duplex multidrop serial link.
// Function
// - Messages shorter than 6 or longer than 250 bytes are size errors.
// - Duplicate when bytes 2, 3, 5, 6 all equal the saved copy.
// - Idle slave ignores everything except start-of-message, poll, acknowledge and negative acknowledge pairs.
// - Start pair clears check and buffer; next code must be our address or, if enabled, broadcast.
// - Wrong address byte drops the frame; back to waiting.
// - Matching address is summed; start-of-text pair must follow.
// - Data is stored and summed; overflow bytes summed but dropped.
// - Errors latched; at frame end check error, check, size, address.
// - Valid duplicate is discarded but still acknowledged.
// - New header saved, message offered to sink; ack only if accepted.
// - Poll takes address then raw check byte, no unstuffing.
// - Poll with wrong address or any error gets no answer.
// - Held message that reached send limit returns with error; else resend.
// - No held message: fetch from source, reset counter, send it.
// - Source empty on accepted poll: answer end-of-transmission pair.
// - Poll answer framed as start-of-text, stuffed data, end, check.
// - Held until acknowledge pair arrives, then discarded.
// - Negative acknowledge drains source, returning each with error.
// - Check byte is two's complement of byte sum; stuffed escape once.
// - Data value escape is sent doubled and collapsed on receive.
// - Optional 16-bit CRC, cleared, reflected 0xA001, low byte first.
`timescale 1ns/1ps
`include "hdps_regs.svh"
module hdps_link #(
  parameter int MSG_MAX = `HDPS_MAX_LEN
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  hdps_pkg::hdps_cfg_s    cfg,
  input  hdps_pkg::hdps_rx_s     rx,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  input  wire logic              tx_ready,
  output logic                   tx_en,
  output logic                   src_req,
  input  wire logic              src_valid,
  input  wire logic [7:0]        src_data,
  input  wire logic              src_last,
  input  wire logic              src_none,
  output logic                   src_done,
  output logic                   src_err,
  input  wire logic              snk_full,
  output logic                   snk_valid,
  output logic [7:0]             snk_data,
  output logic                   snk_last
);
  import hdps_pkg::*;
  localparam logic [7:0] MAXB = 8'(MSG_MAX);

  // CRC update of one byte, reflected form, shifting right eight times.
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ `HDPS_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  logic [7:0] rx_mem [MSG_MAX];
  logic [7:0] tx_mem [MSG_MAX];
  hdps_st_e   st_r, st_nxt;
  hdps_ph_e   ph_r, ph_nxt;
  logic       esc_r, esc_nxt, err_r, err_nxt, held_r, held_nxt, stf_r, stf_nxt;
  logic       hv_r, hv_nxt, txv_r, txv_nxt, sv_r, sv_nxt, sl_r, sl_nxt;
  logic       sd_r, sd_nxt, se_r, se_nxt;
  logic [7:0] sum_r, sum_nxt, len_r, len_nxt, idx_r, idx_nxt, tlen_r, tlen_nxt;
  logic [7:0] sends_r, sends_nxt, ctl_r, ctl_nxt, txd_r, txd_nxt, snd_r, snd_nxt;
  logic [15:0] crc_r, crc_nxt, chk_r, chk_nxt;
  logic [31:0] hdr_r, hdr_nxt, hdr_new;
  logic       rwe, twe, rx_dat, rx_ctl, good, dup, adv;
  logic [7:0] rwa, twa, twd, tb, cur;

  // Escape decoding; a lone escape waits for its partner before meaning anything.
  assign rx_dat  = rx.valid && (esc_r ? (rx.data == `HDPS_DLE) : (rx.data != `HDPS_DLE));
  assign rx_ctl  = rx.valid && esc_r && (rx.data != `HDPS_DLE);
  assign hdr_new = {rx_mem[`HDPS_HDR_B0], rx_mem[`HDPS_HDR_B1],
                    rx_mem[`HDPS_HDR_B2], rx_mem[`HDPS_HDR_B3]};
  assign dup     = hv_r && (hdr_new == hdr_r);
  // All frame-end checks in one term so no single failure can slip through.
  assign good    = !err_r && (len_r >= `HDPS_MIN_LEN) && (len_r <= MAXB)
                   && (cfg.crc_sel ? (crc_r == chk_r) : (8'(sum_r + chk_r[7:0]) == 8'h00))
                   && (!cfg.addr_chk || rx_mem[0] == cfg.station);
  assign cur     = tx_mem[idx_r];
  assign tx_en   = (st_r == S_TX) || (st_r == S_CTL);
  assign src_req = (st_r == S_REQ) || (st_r == S_FREQ);
  assign tx_valid = txv_r;
  assign tx_data  = txd_r;
  assign snk_valid = sv_r;
  assign snk_data  = snd_r;
  assign snk_last  = sl_r;
  assign src_done  = sd_r;
  assign src_err   = se_r;

  // Outgoing byte for the current phase; a stuffed escape repeats the escape.
  always_comb begin
    case (ph_r)
      P_DLE1, P_DLE2: tb = `HDPS_DLE;
      P_CODE:         tb = (st_r == S_CTL) ? ctl_r : `HDPS_STX;
      P_DATA:         tb = stf_r ? `HDPS_DLE : cur;
      P_ETX:          tb = `HDPS_ETX;
      P_CK0:          tb = cfg.crc_sel ? crc_r[7:0] : 8'(8'h00 - sum_r);
      P_CK1:          tb = crc_r[15:8];
      default:        tb = `HDPS_DLE;
    endcase
  end

  // Next-state logic of the whole transceiver; receive and send never overlap.
  always_comb begin
    st_nxt = st_r; ph_nxt = ph_r; esc_nxt = esc_r; err_nxt = err_r; held_nxt = held_r;
    stf_nxt = stf_r; hv_nxt = hv_r; txv_nxt = txv_r; txd_nxt = txd_r; sum_nxt = sum_r;
    len_nxt = len_r; idx_nxt = idx_r; tlen_nxt = tlen_r; sends_nxt = sends_r;
    ctl_nxt = ctl_r; crc_nxt = crc_r; chk_nxt = chk_r; hdr_nxt = hdr_r; snd_nxt = snd_r;
    sv_nxt = 1'b0; sl_nxt = 1'b0; sd_nxt = 1'b0; se_nxt = se_r;
    rwe = 1'b0; rwa = len_r; twe = 1'b0; twa = tlen_r; twd = src_data; adv = 1'b0;
    if (rx.valid) esc_nxt = !esc_r && (rx.data == `HDPS_DLE);
    if (rx.valid && rx.perr) err_nxt = 1'b1;
    // Byte port handshake: load a byte, then advance once the port takes it.
    if (st_r == S_TX || st_r == S_CTL) begin
      esc_nxt = 1'b0;
      if (!txv_r) begin
        txv_nxt = 1'b1;
        txd_nxt = tb;
      end else if (tx_ready) begin
        txv_nxt = 1'b0;
        adv = 1'b1;
      end
    end
    case (st_r)
      S_IDLE: if (rx_ctl) begin
        case (rx.data)
          `HDPS_SOH: begin
            st_nxt = S_ADDR; sum_nxt = 8'h00; len_nxt = 8'h00;
            err_nxt = 1'b0; crc_nxt = 16'h0000;
          end
          `HDPS_ENQ: begin
            st_nxt = S_PADDR; err_nxt = 1'b0;
          end
          `HDPS_ACK: if (held_r) begin
            held_nxt = 1'b0; sd_nxt = 1'b1; se_nxt = 1'b0;
          end
          `HDPS_NAK: begin
            st_nxt = S_FREQ;
            if (held_r) begin
              held_nxt = 1'b0; sd_nxt = 1'b1; se_nxt = 1'b1;
            end
          end
          default: st_nxt = S_IDLE;
        endcase
      end
      S_ADDR: if (rx_dat) begin
        if (rx.data == cfg.station || (cfg.bcast_en && rx.data == `HDPS_BCAST)) begin
          sum_nxt = 8'(sum_r + rx.data);
          st_nxt = S_STX;
        end else st_nxt = S_IDLE;
      end else if (rx_ctl) st_nxt = S_IDLE;
      S_STX: if (rx_ctl && rx.data == `HDPS_STX) st_nxt = S_BUILD;
        else if (rx_ctl || rx_dat) st_nxt = S_IDLE;
      S_BUILD: if (rx_dat) begin
        sum_nxt = 8'(sum_r + rx.data);
        crc_nxt = crc_upd(crc_r, rx.data);
        rwe = (len_r < MAXB);
        if (len_r != 8'hFF) len_nxt = len_r + 8'h01;
      end else if (rx_ctl) begin
        if (rx.data == `HDPS_ETX) begin
          crc_nxt = crc_upd(crc_r, `HDPS_ETX);
          st_nxt = S_CHK;
        end else st_nxt = S_IDLE;
      end
      S_CHK: begin
        esc_nxt = 1'b0;
        if (rx.valid) begin
          chk_nxt[7:0] = rx.data;
          st_nxt = cfg.crc_sel ? S_CHK2 : S_JUDGE;
        end
      end
      S_CHK2: begin
        esc_nxt = 1'b0;
        if (rx.valid) begin
          chk_nxt[15:8] = rx.data;
          st_nxt = S_JUDGE;
        end
      end
      S_JUDGE: begin
        ctl_nxt = `HDPS_ACK;
        ph_nxt = P_DLE1;
        idx_nxt = 8'h00;
        if (!good) st_nxt = S_IDLE;
        else if (dup) st_nxt = S_CTL;
        else begin
          hdr_nxt = hdr_new;
          hv_nxt = 1'b1;
          st_nxt = snk_full ? S_IDLE : S_DELIV;
        end
      end
      S_DELIV: begin
        sv_nxt = 1'b1;
        snd_nxt = rx_mem[idx_r];
        sl_nxt = (idx_r == 8'(len_r - 8'h01));
        idx_nxt = idx_r + 8'h01;
        if (sl_nxt) st_nxt = S_CTL;
      end
      S_PADDR: if (rx_dat) begin
        chk_nxt[7:0] = rx.data;
        st_nxt = S_PBCC;
      end else if (rx_ctl) st_nxt = S_IDLE;
      S_PBCC: begin
        esc_nxt = 1'b0;
        if (rx.valid) begin
          if (!err_r && !rx.perr && chk_nxt[7:0] == cfg.station
              && 8'(chk_r[7:0] + rx.data) == 8'h00) st_nxt = S_POLL;
          else st_nxt = S_IDLE;
        end
      end
      S_POLL: begin
        ph_nxt = P_DLE1; idx_nxt = 8'h00; sum_nxt = 8'h00; crc_nxt = 16'h0000; stf_nxt = 1'b0;
        if (!held_r) begin
          st_nxt = S_REQ;
          tlen_nxt = 8'h00;
        end else if (sends_r >= cfg.max_sends) begin
          held_nxt = 1'b0; sd_nxt = 1'b1; se_nxt = 1'b1;
          st_nxt = S_REQ; tlen_nxt = 8'h00;
        end else begin
          st_nxt = S_TX;
          sends_nxt = sends_r + 8'h01;
        end
      end
      S_REQ: st_nxt = S_FETCH;
      S_FETCH: if (src_none) begin
        st_nxt = S_CTL; ctl_nxt = `HDPS_EOT; ph_nxt = P_DLE1;
      end else if (src_valid) begin
        twe = (tlen_r < MAXB);
        if (twe) tlen_nxt = tlen_r + 8'h01;
        if (src_last) begin
          held_nxt = 1'b1; sends_nxt = 8'h01; st_nxt = S_TX;
        end
      end
      S_TX: if (adv) begin
        case (ph_r)
          P_DLE1: ph_nxt = P_CODE;
          P_CODE: ph_nxt = P_DATA;
          P_DATA: begin
            stf_nxt = !stf_r && (cur == `HDPS_DLE);
            if (!stf_nxt) begin
              sum_nxt = 8'(sum_r + cur);
              crc_nxt = crc_upd(crc_r, cur);
              idx_nxt = idx_r + 8'h01;
              if (idx_nxt >= tlen_r) ph_nxt = P_DLE2;
            end
          end
          P_DLE2: ph_nxt = P_ETX;
          P_ETX: begin
            crc_nxt = crc_upd(crc_r, `HDPS_ETX);
            ph_nxt = P_CK0;
          end
          P_CK0: if (cfg.crc_sel) ph_nxt = P_CK1;
            else st_nxt = S_IDLE;
          default: st_nxt = S_IDLE;
        endcase
      end
      S_CTL: if (adv) begin
        if (ph_r == P_DLE1) ph_nxt = P_CODE;
        else st_nxt = S_IDLE;
      end
      S_FREQ: st_nxt = S_FDRAIN;
      S_FDRAIN: if (src_none) st_nxt = S_IDLE;
        else if (src_valid && src_last) begin
          sd_nxt = 1'b1; se_nxt = 1'b1; st_nxt = S_FREQ;
        end
      default: st_nxt = S_IDLE;
    endcase
  end

  // State registers; buffers carry no reset since length counters guard them.
  always_ff @(posedge clock) begin
    if (rwe) rx_mem[rwa] <= rx.data;
    if (twe) tx_mem[twa] <= twd;
    if (!rst_n) begin
      st_r <= S_IDLE; ph_r <= P_DLE1; esc_r <= 1'b0; err_r <= 1'b0; held_r <= 1'b0;
      stf_r <= 1'b0; hv_r <= 1'b0; txv_r <= 1'b0; txd_r <= 8'h00; sum_r <= 8'h00;
      len_r <= 8'h00; idx_r <= 8'h00; tlen_r <= 8'h00; sends_r <= 8'h00; ctl_r <= 8'h00;
      crc_r <= 16'h0000; chk_r <= 16'h0000; hdr_r <= 32'h0000_0000; snd_r <= 8'h00;
      sv_r <= 1'b0; sl_r <= 1'b0; sd_r <= 1'b0; se_r <= 1'b0;
    end else begin
      st_r <= st_nxt; ph_r <= ph_nxt; esc_r <= esc_nxt; err_r <= err_nxt;
      held_r <= held_nxt; stf_r <= stf_nxt; hv_r <= hv_nxt; txv_r <= txv_nxt;
      txd_r <= txd_nxt; sum_r <= sum_nxt; len_r <= len_nxt; idx_r <= idx_nxt;
      tlen_r <= tlen_nxt; sends_r <= sends_nxt; ctl_r <= ctl_nxt; crc_r <= crc_nxt;
      chk_r <= chk_nxt; hdr_r <= hdr_nxt; snd_r <= snd_nxt; sv_r <= sv_nxt;
      sl_r <= sl_nxt; sd_r <= sd_nxt; se_r <= se_nxt;
    end
  end

  // Checks on the protocol decisions above.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_txen_only_resp: assert property (tx_valid |-> tx_en)
    else $error("byte offered while transmit disabled");
  a_idle_ignores: assert property (st_r == S_IDLE && !rx_ctl |=> st_r == S_IDLE)
    else $error("idle left without control pair");
  a_addr_miss: assert property (st_r == S_ADDR && rx_dat && rx.data != cfg.station
    && !(cfg.bcast_en && rx.data == `HDPS_BCAST) |=> st_r == S_IDLE)
    else $error("foreign frame not dropped");
  a_size_drop: assert property (st_r == S_JUDGE && len_r < `HDPS_MIN_LEN
    |=> st_r == S_IDLE ##1 !snk_valid)
    else $error("short message not dropped");
  a_dup_acked: assert property (st_r == S_JUDGE && good && dup
    |=> st_r == S_CTL && ctl_r == `HDPS_ACK ##[1:3] tx_valid && tx_data == `HDPS_DLE)
    else $error("duplicate not acknowledged");
  a_full_silent: assert property (st_r == S_JUDGE && good && !dup && snk_full
    |=> st_r == S_IDLE && !snk_valid)
    else $error("message kept while sink full");
  a_poll_bad: assert property (st_r == S_PBCC && rx.valid
    && 8'(chk_r[7:0] + rx.data) != 8'h00 |=> st_r == S_IDLE)
    else $error("bad poll answered");
  a_eot_answer: assert property (st_r == S_FETCH && src_none
    |=> st_r == S_CTL && ctl_r == `HDPS_EOT)
    else $error("empty source not answered");
  a_nak_flush: assert property (st_r == S_IDLE && rx_ctl && rx.data == `HDPS_NAK
    |=> st_r == S_FREQ && src_req)
    else $error("link reset did not drain source");
  a_stuff_pair: assert property (st_r == S_TX && ph_r == P_DATA && tx_valid && tx_ready
    && !stf_r && tx_data == `HDPS_DLE |-> ##2 tx_valid && tx_data == `HDPS_DLE)
    else $error("escape data byte not doubled");
  c_deliver: cover property (snk_valid && snk_last);
  c_eot: cover property (st_r == S_CTL && ctl_r == `HDPS_EOT && tx_valid);
  c_resend: cover property (st_r == S_POLL && held_r);
  c_flush: cover property (st_r == S_FREQ && src_done && src_err);
endmodule // hdps_link

// File: verification/hdps_master_model.sv
// Polling master station model that drives the slave's receive and transmit handshake.
`timescale 1ns/1ps
`include "hdps_regs.svh"
module hdps_master_model (
  input  wire logic          clock,
  output hdps_pkg::hdps_rx_s rx,
  output logic               tx_ready,
  input  wire logic          slow
);
  import hdps_pkg::*;
  // The line starts quiet; the port takes nothing until the first edge.
  initial begin
    rx = '0;
    tx_ready = 1'b0;
  end
  // A slow port stalls every other cycle, so the slave must hold each byte.
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  // One byte per pulse; between bytes the data shows its inverse, never a stale copy.
  task automatic put(input logic [7:0] b, input logic p);
    @(negedge clock);
    rx <= '{1'b1, b, p};
    @(negedge clock);
    rx <= '{1'b0, ~b, 1'b0};
  endtask
  // A data value equal to the escape goes out doubled.
  task automatic put_data(input logic [7:0] b, input logic p);
    if (b == `HDPS_DLE) put(`HDPS_DLE, 1'b0);
    put(b, p);
  endtask
  task automatic ctl(input logic [7:0] c);
    put(`HDPS_DLE, 1'b0);
    put(c, 1'b0);
  endtask
  // Poll check covers only the station; bad spoils it on purpose.
  task automatic poll(input logic [7:0] stn, input logic [7:0] bad);
    ctl(`HDPS_ENQ);
    put_data(stn, 1'b0);
    put(8'h00 - stn + bad, 1'b0);
  endtask
endmodule // hdps_master_model

// File: verification/hdps_link_test.sv
// Self-checking bench of the polled slave link transceiver.
`timescale 1ns/1ps
`include "hdps_regs.svh"
module hdps_link_test;
  import hdps_pkg::*;
  logic        clock, rst_n, slow, tx_ready, tx_valid, tx_en;
  logic        src_req, src_valid, src_last, src_none, src_done, src_err;
  logic        snk_full, snk_valid, snk_last;
  logic [7:0]  tx_data, src_data, snk_data;
  logic [15:0] lfsr;
  hdps_cfg_s   cfg;
  hdps_rx_s    rx;
  logic [7:0]  m[0:299];
  logic [7:0]  exp_tx[$], src_q[$];
  logic [8:0]  exp_snk[$];
  logic        exp_done[$];
  int          src_n[$];
  int          error_cnt, checks, seq;

  hdps_link #(.MSG_MAX(250)) i_hdps_link (.clock(clock), .rst_n(rst_n), .cfg(cfg), .rx(rx),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_en(tx_en),
    .src_req(src_req), .src_valid(src_valid), .src_data(src_data), .src_last(src_last),
    .src_none(src_none), .src_done(src_done), .src_err(src_err), .snk_full(snk_full),
    .snk_valid(snk_valid), .snk_data(snk_data), .snk_last(snk_last));
  hdps_master_model i_hdps_master_model (.clock(clock), .rx(rx), .tx_ready(tx_ready),
    .slow(slow));

  // Free-running clock of 50 ns.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Each result seen at the ports is matched against the oldest note; FFFF marks an extra.
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      check({15'h0000, tx_en}, 16'h0001);
      check({8'h00, tx_data}, exp_tx.size() ? {8'h00, exp_tx.pop_front()} : 16'hFFFF);
    end
    if (snk_valid === 1'b1)
      check({7'h00, snk_last, snk_data}, exp_snk.size() ? exp_snk.pop_front() : 16'hFFFF);
    if (src_done === 1'b1)
      check({15'h0000, src_err}, exp_done.size() ? exp_done.pop_front() : 16'hFFFF);
  end

  // Source answers each request two cycles later with one message or with empty.
  initial begin
    int n;
    src_valid = 1'b0;
    src_data = 8'h00;
    src_last = 1'b0;
    src_none = 1'b0;
    forever begin
      @(posedge clock);
      if (src_req === 1'b1) begin
        repeat (2) @(negedge clock);
        n = src_n.size() ? src_n.pop_front() : 0;
        src_none <= (n == 0);
        for (int i = 0; i < n; i++) begin
          src_valid <= 1'b1;
          src_data <= src_q.pop_front();
          src_last <= (i == n - 1);
          @(negedge clock);
        end
        if (n == 0) @(negedge clock);
        src_valid <= 1'b0;
        src_last <= 1'b0;
        src_none <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Header byte 1 carries a sequence number so successive messages always differ.
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      m[i] = lfsr[7:0];
    end
    m[1] = seq[7:0];
    m[2] = `HDPS_DLE;
    seq++;
  endtask

  // Byte check is the negated sum including first; CRC covers data and end byte.
  function automatic logic [15:0] chk(input int n, input logic [7:0] first, input logic crc);
    logic [15:0] c;
    c = {8'h00, first};
    for (int i = 0; i < n; i++) c[7:0] += m[i];
    if (!crc) return {8'h00, 8'h00 - c[7:0]};
    c = 16'h0000;
    for (int i = 0; i <= n; i++) begin
      c ^= {8'h00, (i == n) ? `HDPS_ETX : m[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `HDPS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic note_pair(input logic [7:0] c);
    exp_tx.push_back(`HDPS_DLE);
    exp_tx.push_back(c);
  endtask

  task automatic note_rx(input int n);
    for (int i = 0; i < n; i++) exp_snk.push_back({i == n - 1, m[i]});
    note_pair(`HDPS_ACK);
  endtask

  // Poll answer: start pair, stuffed data, end pair, check low byte first.
  task automatic note_frame(input int n);
    logic [15:0] c;
    c = chk(n, 8'h00, cfg.crc_sel);
    note_pair(`HDPS_STX);
    for (int i = 0; i < n; i++) begin
      if (m[i] == `HDPS_DLE) exp_tx.push_back(`HDPS_DLE);
      exp_tx.push_back(m[i]);
    end
    note_pair(`HDPS_ETX);
    exp_tx.push_back(c[7:0]);
    if (cfg.crc_sel) exp_tx.push_back(c[15:8]);
  endtask

  task automatic load_src(input int n);
    fill(n);
    src_n.push_back(n);
    for (int i = 0; i < n; i++) src_q.push_back(m[i]);
  endtask

  // Master frame; err 1 spoils parity of one byte, err 2 spoils the check.
  task automatic send_msg(input logic [7:0] stn, input int n, input int err);
    logic [15:0] c;
    c = chk(n, stn, cfg.crc_sel) + 16'(err == 2);
    i_hdps_master_model.ctl(`HDPS_SOH);
    i_hdps_master_model.put_data(stn, 1'b0);
    i_hdps_master_model.ctl(`HDPS_STX);
    for (int i = 0; i < n; i++) i_hdps_master_model.put_data(m[i], err == 1 && i == 3);
    i_hdps_master_model.ctl(`HDPS_ETX);
    i_hdps_master_model.put(c[7:0], 1'b0);
    if (cfg.crc_sel) i_hdps_master_model.put(c[15:8], 1'b0);
  endtask

  // Waits, bounded, for all notes to be met, then a quiet spell that exposes extras.
  task automatic settle(input string name);
    int k;
    k = 0;
    while (exp_tx.size() + exp_snk.size() + exp_done.size() != 0 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    repeat (40) @(negedge clock);
    check(16'(exp_tx.size() + exp_snk.size() + exp_done.size()), 16'h0000);
    $display("test %s finished", name);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog sized well beyond the expected run of about three and a half thousand cycles.
  initial begin
    #(50 * 60000);
    error_cnt++;
    final_report();
  end

  // Main sequence: receive path, faults, then polls, limit, acknowledge, CRC and flush.
  initial begin
    int len;
    rst_n = 1'b0;
    slow = 1'b0;
    snk_full = 1'b0;
    lfsr = 16'h825A;
    seq = 0;
    error_cnt = 0;
    checks = 0;
    cfg = '{max_sends: 8'h02, station: 8'h20, bcast_en: 1'b1, crc_sel: 1'b0, addr_chk: 1'b0};
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    fill(6);
    note_rx(6);
    send_msg(8'h20, 6, 0);
    settle("deliver");
    for (int k = 0; k < 6; k++) begin
      m[k] = m[k] ^ 8'h5A;
      if (k inside {1, 2, 4, 5}) note_rx(6);
      else note_pair(`HDPS_ACK);
      send_msg(8'h20, 6, 0);
      settle("header byte");
    end
    i_hdps_master_model.ctl(`HDPS_STX);
    i_hdps_master_model.put(8'h20, 1'b0);
    settle("stray codes");
    // Frame 6 is a broadcast with broadcast off; frame 7 carries a foreign first byte.
    for (int e = 0; e < 8; e++) begin
      len = (e == 4) ? 251 : ((e == 3) ? 5 : 6);
      fill(len);
      if (e == 7) m[0] = 8'h21;
      snk_full = (e == 5);
      cfg.bcast_en = (e != 6);
      cfg.addr_chk = (e == 7);
      send_msg((e == 0) ? 8'h21 : ((e == 6) ? 8'hFF : 8'h20), len, e);
      settle("faulty frame");
    end
    snk_full = 1'b0;
    cfg.bcast_en = 1'b1;
    cfg.addr_chk = 1'b0;
    fill(250);
    note_rx(250);
    send_msg(8'hFF, 250, 0);
    settle("broadcast");
    i_hdps_master_model.poll(8'h21, 8'h00);
    i_hdps_master_model.poll(8'h20, 8'h01);
    settle("foreign poll");
    note_pair(`HDPS_EOT);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("empty poll");
    slow = 1'b1;
    load_src(6);
    note_frame(6);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("answer");
    note_frame(6);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("resend");
    exp_done.push_back(1'b1);
    load_src(7);
    note_frame(7);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("limit");
    exp_done.push_back(1'b0);
    i_hdps_master_model.ctl(`HDPS_ACK);
    settle("acknowledge");
    note_pair(`HDPS_EOT);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("after acknowledge");
    cfg.crc_sel = 1'b1;
    load_src(8);
    note_frame(8);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("crc answer");
    fill(9);
    note_rx(9);
    send_msg(8'h20, 9, 0);
    settle("crc message");
    // The acknowledge waits for the slave's own reply; on a half-duplex line it would be lost.
    exp_done.push_back(1'b0);
    i_hdps_master_model.ctl(`HDPS_ACK);
    settle("crc acknowledge");
    load_src(6);
    note_frame(6);
    i_hdps_master_model.poll(8'h20, 8'h00);
    settle("held");
    exp_done.push_back(1'b1);
    exp_done.push_back(1'b1);
    load_src(6);
    i_hdps_master_model.ctl(`HDPS_NAK);
    settle("flush");
    final_report();
  end
endmodule // hdps_link_test
